// File: mic_consts.svh
// offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH

`define MIC_NSRC            8
`define MIC_NNMI            2

`define MIC_REG_STATUS      3'h0
`define MIC_REG_PRIO        3'h1
`define MIC_REG_CTRL        3'h2
`define MIC_REG_FLAGS       3'h3
`define MIC_REG_NMIEN       3'h4

`define MIC_ST_NMI_BIT      7
`define MIC_CTRL_ROUND_ROBIN_ENABLE_BIT   7
`define MIC_FLAGS_NMI_LSB   8

`define MIC_CTRL_RST        3'h0
`define MIC_PRIO_RST        8'h00
`define MIC_NMIEN_RST       2'h0

`define MIC_RESET_VEC       8'h00
`define MIC_NMI_VEC_BASE    8'h01
`define MIC_SRC_VEC_BASE    8'h03

`define MIC_RESP_CYC        5
`define MIC_WAKE_EXTRA_CYC  5
`define MIC_WAKE_START_CYC  4
`define MIC_JUMP_CYC        3
`define MIC_RET_CYC         5
`define MIC_CCP_CYC         4

`endif

// File: mic_pkg.sv
// types of the interrupt controller
package mic_pkg;

   typedef enum logic [2:0] {
      MIC_RANK_NONE,
      MIC_RANK_LOW,
      MIC_RANK_MED,
      MIC_RANK_HIGH,
      MIC_RANK_NMI
   } mic_rank_t;

   typedef enum logic [1:0] {
      MIC_LVL_OFF  = 2'h0,
      MIC_LVL_LOW  = 2'h1,
      MIC_LVL_MED  = 2'h2,
      MIC_LVL_HIGH = 2'h3
   } mic_lvl_t;

   typedef enum {
      MIC_ST_IDLE,
      MIC_ST_REQ,
      MIC_ST_RESP,
      MIC_ST_JUMP,
      MIC_ST_RET
   } mic_st_t;

   // cpu side signals, all on the cpu clock
   typedef struct packed {
      logic gie;         // global interrupt enable of the cpu status register
      logic boundary;    // cpu is between instructions
      logic insn_done;   // pulse: one instruction completed
      logic ack;         // pulse: cpu takes the presented vector
      logic interrupt_return_instruction;        // pulse: interrupt return instruction executed
      logic sleep;       // cpu is asleep
      logic ccp_sig;     // pulse: protection register got the signature
   } mic_cpu_in_t;

   // executing levels
   typedef struct packed {
      logic nmi;
      logic high;
      logic level_medium;
      logic low;
   } mic_exec_t;

endpackage

// File: mic_pick.sv
// first requester from a start position, wrapping around
`timescale 1ns/100ps
module mic_pick #(
   parameter int N = 8
) (
   input  wire logic [N-1:0]         i_req,    // requests, index 0 highest at start 0
   input  wire logic [$clog2(N)-1:0] i_start,  // index that gets highest priority
   output logic                      o_any,    // some request present
   output logic [$clog2(N)-1:0]      o_idx     // chosen index
);
   import mic_pkg::*;

   always_comb
   begin
      int p;
      p     = 0;
      o_any = 1'b0;
      o_idx = '0;
      for (int k = N - 1; k >= 0; k--)
      begin
         p = int'(i_start) + k;
         if (p >= N)
         begin
            p = p - N;
         end
         if (i_req[p])
         begin
            o_any = 1'b1;
            o_idx = ($clog2(N))'(p);
         end
      end
   end

endmodule // mic_pick

// File: mic_avs.sv
// avalon-mm handshake: one wait cycle, then a one-cycle answer
`timescale 1ns/100ps
module mic_avs (
   input  wire logic i_clk,          // cpu clock
   input  wire logic i_rstn,         // synchronous reset, active low
   input  wire logic i_read,         // avalon read
   input  wire logic i_write,        // avalon write
   output logic      o_waitrequest,  // avalon waitrequest, registered
   output logic      o_take          // access completes at this edge
);
   import mic_pkg::*;

   typedef struct packed {
      logic waitreq;
   } mic_avs_st_t;

   mic_avs_st_t st;
   mic_avs_st_t next_st;

   assign o_waitrequest = st.waitreq;
   assign o_take        = (i_read || i_write) && !st.waitreq;

   always_comb
   begin
      next_st = st;
      if (o_take)
      begin
         next_st.waitreq = 1'b1;
      end
      else if (i_read || i_write)
      begin
         next_st.waitreq = 1'b0;
      end
      else
      begin
         next_st.waitreq = 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         st.waitreq <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

endmodule // mic_avs

// File: mic_ctrl.sv
// multilevel interrupt controller: arbitration, nesting, latencies, registers
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`include "mic_consts.svh"

// Functional notes
// - maskable interrupts only when cpu global enable set; acknowledge never touches it
// - maskable request needs its own level enable too
// - level code per source: 00 off, 01 low, 10 medium, 11 high
// - higher level preempts lower handler; lower resumes after higher returns
// - static priority: lowest vector address first within a level
// - round-robin: last acknowledged low vector gets lowest low priority next
// - high, medium and nmi always use fixed vector priority
// - request acknowledged only if it beats running handler; else stays pending
// - acknowledge loads program counter with the request's own vector
// - one instruction runs after return or enable before next interrupt
// - interrupt return restores previous level state; subroutine return does not
// - flag sets on condition even when source disabled; stays until served or cleared
// - flags clear on vector execution or software write of one
// - conditions during global disable stay flagged, served by priority afterwards
// - after protection signature, acknowledgement suppressed for 4 cycles
// - nmi ignores and never changes global enable; needs its own enable
// - nothing preempts nmi handler; lowest nmi vector first
// - response takes five push cycles, then three jump cycles
// - multi-cycle instruction completes before interrupt taken
// - wake from sleep adds five cycles plus sleep start-up time
// - return takes five cycles popping program counter
// - reset vector lowest address, each interrupt its own vector above
// - executing flag per level set while running or preempted, cleared by return
// - round-robin enable selects rotating or fixed low priority
// - last low vector writable, kept when round-robin off; write zero for static
// - cleared level enable ignores that level's requests
module mic_ctrl
   import mic_pkg::*;
(
   input  wire logic                          I_CLK,             // 200 MHz cpu clock
   input  wire logic                          I_RSTN,            // sync reset, active low
   input  wire logic [`MIC_NSRC-1:0]          I_SRC_COND,        // source condition pulses
   input  wire mic_pkg::mic_lvl_t [`MIC_NSRC-1:0] I_SRC_LVL,     // per-source level code
   input  wire logic [`MIC_NNMI-1:0]          I_NMI_COND,        // nmi condition pulses
   input  wire mic_pkg::mic_cpu_in_t          I_CPU,             // cpu status and strobes
   input  wire logic [2:0]                    I_AVS_ADDRESS,     // avalon word address
   input  wire logic                          I_AVS_READ,        // avalon read
   input  wire logic                          I_AVS_WRITE,       // avalon write
   input  wire logic [31:0]                   I_AVS_WRITEDATA,   // avalon write data
   output logic [31:0]                        O_AVS_READDATA,    // avalon read data
   output logic                               O_AVS_WAITREQUEST, // avalon waitrequest
   output logic                               O_IRQ_REQ,         // vector presented
   output logic [7:0]                         O_IRQ_VEC,         // presented vector
   output logic                               O_PUSH,            // response: pc push phase
   output logic                               O_JUMP,            // jump to handler phase
   output logic                               O_PC_LOAD,         // pulse: load pc
   output logic [7:0]                         O_PC_VEC,          // value loaded into pc
   output logic                               O_POP,             // return: pc pop phase
   output mic_pkg::mic_exec_t                 O_EXEC             // executing levels
);
   import mic_pkg::*;

   localparam int SW = $clog2(`MIC_NSRC);
   localparam int NW = $clog2(`MIC_NNMI);

   typedef struct packed {
      mic_st_t                st;
      logic [4:0]             cnt;
      logic [`MIC_NSRC-1:0]   flag;
      logic [`MIC_NNMI-1:0]   nmi_flag;
      logic [`MIC_NNMI-1:0]   nmi_en;
      logic [7:0]             last_low_vector;
      logic                   round_robin_enable;
      logic [2:0]             lvl_en;
      mic_exec_t              exec;
      logic                   hold;
      logic [2:0]             ccp_cnt;
      logic                   gie_q;
      mic_rank_t              win_rank;
      logic [SW-1:0]          win_idx;
      logic [7:0]             vec;
      logic                   pc_load;
      logic [31:0]            rdata;
   } mic_state_t;

   mic_state_t s;
   mic_state_t next_s;

   logic                 avs_take;
   logic [`MIC_NSRC-1:0] req_high;
   logic [`MIC_NSRC-1:0] req_med;
   logic [`MIC_NSRC-1:0] req_low;
   logic [SW-1:0]        low_start;
   logic                 any_high;
   logic                 any_med;
   logic                 any_low;
   logic                 any_nmi;
   logic [SW-1:0]        idx_high;
   logic [SW-1:0]        idx_med;
   logic [SW-1:0]        idx_low;
   logic [NW-1:0]        idx_nmi;
   mic_rank_t            cand_rank;
   logic [SW-1:0]        cand_idx;
   logic [7:0]           cand_vec;
   mic_rank_t            cur_rank;
   logic                 allow;
   logic                 wins;

   // rank of the innermost handler in progress
   function automatic mic_rank_t rank_of(input mic_exec_t e);
      if (e.nmi)
      begin
         return MIC_RANK_NMI;
      end
      else if (e.high)
      begin
         return MIC_RANK_HIGH;
      end
      else if (e.level_medium)
      begin
         return MIC_RANK_MED;
      end
      else if (e.low)
      begin
         return MIC_RANK_LOW;
      end
      return MIC_RANK_NONE;
   endfunction

   function automatic logic [7:0] src_vec(input logic [SW-1:0] idx);
      return `MIC_SRC_VEC_BASE + 8'(idx);
   endfunction

   function automatic logic [7:0] nmi_vec(input logic [SW-1:0] idx);
      return `MIC_NMI_VEC_BASE + 8'(idx);
   endfunction

   mic_avs u_avs (
      .i_clk         (I_CLK),
      .i_rstn        (I_RSTN),
      .i_read        (I_AVS_READ),
      .i_write       (I_AVS_WRITE),
      .o_waitrequest (O_AVS_WAITREQUEST),
      .o_take        (avs_take)
   );

   // per-level request vectors from flags and level codes
   generate
      for (genvar g = 0; g < `MIC_NSRC; g++)
      begin : g_req
         assign req_high[g] = s.flag[g] && (I_SRC_LVL[g] == MIC_LVL_HIGH);
         assign req_med[g]  = s.flag[g] && (I_SRC_LVL[g] == MIC_LVL_MED);
         assign req_low[g]  = s.flag[g] && (I_SRC_LVL[g] == MIC_LVL_LOW);
      end
   endgenerate

   // start just past the last low vector when rotating
   always_comb
   begin
      logic [7:0] off;
      off       = s.last_low_vector - `MIC_SRC_VEC_BASE;
      low_start = '0;
      if (s.round_robin_enable && (s.last_low_vector >= `MIC_SRC_VEC_BASE)
          && (off < 8'(`MIC_NSRC)))
      begin
         low_start = SW'(off) + SW'(1);
      end
   end

   mic_pick #(.N(`MIC_NSRC)) u_pick_high (
      .i_req   (req_high),
      .i_start ('0),
      .o_any   (any_high),
      .o_idx   (idx_high)
   );

   mic_pick #(.N(`MIC_NSRC)) u_pick_med (
      .i_req   (req_med),
      .i_start ('0),
      .o_any   (any_med),
      .o_idx   (idx_med)
   );

   mic_pick #(.N(`MIC_NSRC)) u_pick_low (
      .i_req   (req_low),
      .i_start (low_start),
      .o_any   (any_low),
      .o_idx   (idx_low)
   );

   mic_pick #(.N(`MIC_NNMI)) u_pick_nmi (
      .i_req   (s.nmi_flag & s.nmi_en),
      .i_start ('0),
      .o_any   (any_nmi),
      .o_idx   (idx_nmi)
   );

   // candidate across levels; lowest vector wins inside one level, except low when rotating
   always_comb
   begin
      cand_rank = MIC_RANK_NONE;
      cand_idx  = '0;
      cand_vec  = `MIC_RESET_VEC;
      if (any_nmi)
      begin
         cand_rank = MIC_RANK_NMI;
         cand_idx  = SW'(idx_nmi);
         cand_vec  = nmi_vec(SW'(idx_nmi));
      end
      else if (I_CPU.gie && s.lvl_en[2] && any_high)
      begin
         cand_rank = MIC_RANK_HIGH;
         cand_idx  = idx_high;
         cand_vec  = src_vec(idx_high);
      end
      else if (I_CPU.gie && s.lvl_en[1] && any_med)
      begin
         cand_rank = MIC_RANK_MED;
         cand_idx  = idx_med;
         cand_vec  = src_vec(idx_med);
      end
      else if (I_CPU.gie && s.lvl_en[0] && any_low)
      begin
         cand_rank = MIC_RANK_LOW;
         cand_idx  = idx_low;
         cand_vec  = src_vec(idx_low);
      end
   end

   assign cur_rank = rank_of(s.exec);
   // no request at instruction middle, right after return/enable, or during protection
   assign allow    = I_CPU.boundary && !s.hold && (s.ccp_cnt == 3'h0);
   assign wins     = allow && (cand_rank > cur_rank);

   always_comb
   begin
      logic [`MIC_NSRC-1:0] clr_src;
      logic [`MIC_NNMI-1:0] clr_nmi;
      logic                 wr;
      clr_src = '0;
      clr_nmi = '0;
      wr      = avs_take && I_AVS_WRITE;
      next_s  = s;
      next_s.pc_load = 1'b0;
      next_s.gie_q   = I_CPU.gie;

      // protection window
      if (I_CPU.ccp_sig)
      begin
         next_s.ccp_cnt = 3'(`MIC_CCP_CYC);
      end
      else if (s.ccp_cnt != 3'h0)
      begin
         next_s.ccp_cnt = s.ccp_cnt - 3'h1;
      end

      // one instruction after enable or return
      if (I_CPU.gie && !s.gie_q)
      begin
         next_s.hold = 1'b1;
      end
      else if (I_CPU.insn_done)
      begin
         next_s.hold = 1'b0;
      end

      unique case (s.st)
         MIC_ST_IDLE:
         begin
            if (I_CPU.interrupt_return_instruction && (s.exec != '0))
            begin
               next_s.st  = MIC_ST_RET;
               next_s.cnt = 5'(`MIC_RET_CYC - 1);
            end
            else if (wins)
            begin
               next_s.st       = MIC_ST_REQ;
               next_s.win_rank = cand_rank;
               next_s.win_idx  = cand_idx;
               next_s.vec      = cand_vec;
            end
         end
         MIC_ST_REQ:
         begin
            if (I_CPU.ack)
            begin
               // executing levels get set only here
               unique case (s.win_rank)
                  MIC_RANK_NMI:  next_s.exec.nmi  = 1'b1;
                  MIC_RANK_HIGH: next_s.exec.high = 1'b1;
                  MIC_RANK_MED:  next_s.exec.level_medium  = 1'b1;
                  MIC_RANK_LOW:  next_s.exec.low  = 1'b1;
                  default:       next_s.exec      = s.exec;
               endcase
               if (s.win_rank == MIC_RANK_NMI)
               begin
                  clr_nmi[NW'(s.win_idx)] = 1'b1;
               end
               else
               begin
                  clr_src[s.win_idx] = 1'b1;
               end
               if ((s.win_rank == MIC_RANK_LOW) && s.round_robin_enable)
               begin
                  next_s.last_low_vector = s.vec;
               end
               next_s.st  = MIC_ST_RESP;
               next_s.cnt = I_CPU.sleep
                  ? 5'(`MIC_RESP_CYC + `MIC_WAKE_EXTRA_CYC + `MIC_WAKE_START_CYC - 1)
                  : 5'(`MIC_RESP_CYC - 1);
            end
            else if (I_CPU.interrupt_return_instruction && (s.exec != '0))
            begin
               next_s.st  = MIC_ST_RET;
               next_s.cnt = 5'(`MIC_RET_CYC - 1);
            end
            else if (!wins)
            begin
               next_s.st = MIC_ST_IDLE;
            end
            else
            begin
               next_s.win_rank = cand_rank;
               next_s.win_idx  = cand_idx;
               next_s.vec      = cand_vec;
            end
         end
         MIC_ST_RESP:
         begin
            if (s.cnt == 5'h0)
            begin
               next_s.st  = MIC_ST_JUMP;
               next_s.cnt = 5'(`MIC_JUMP_CYC - 1);
            end
            else
            begin
               next_s.cnt = s.cnt - 5'h1;
            end
         end
         MIC_ST_JUMP:
         begin
            if (s.cnt == 5'h0)
            begin
               next_s.st      = MIC_ST_IDLE;
               next_s.pc_load = 1'b1;
            end
            else
            begin
               next_s.cnt = s.cnt - 5'h1;
            end
         end
         MIC_ST_RET:
         begin
            if (s.cnt == 5'h0)
            begin
               next_s.st   = MIC_ST_IDLE;
               next_s.hold = 1'b1;
               // innermost level leaves, outer one resumes
               if (s.exec.nmi)
               begin
                  next_s.exec.nmi = 1'b0;
               end
               else if (s.exec.high)
               begin
                  next_s.exec.high = 1'b0;
               end
               else if (s.exec.level_medium)
               begin
                  next_s.exec.level_medium = 1'b0;
               end
               else
               begin
                  next_s.exec.low = 1'b0;
               end
            end
            else
            begin
               next_s.cnt = s.cnt - 5'h1;
            end
         end
      endcase

      // register writes
      if (wr)
      begin
         unique case (I_AVS_ADDRESS)
            `MIC_REG_PRIO: next_s.last_low_vector = I_AVS_WRITEDATA[7:0];
            `MIC_REG_CTRL:
            begin
               next_s.round_robin_enable = I_AVS_WRITEDATA[`MIC_CTRL_ROUND_ROBIN_ENABLE_BIT];
               next_s.lvl_en             = I_AVS_WRITEDATA[2:0];
            end
            `MIC_REG_FLAGS:
            begin
               clr_src = clr_src | I_AVS_WRITEDATA[`MIC_NSRC-1:0];
               clr_nmi = clr_nmi
                       | I_AVS_WRITEDATA[`MIC_FLAGS_NMI_LSB +: `MIC_NNMI];
            end
            `MIC_REG_NMIEN: next_s.nmi_en = I_AVS_WRITEDATA[`MIC_NNMI-1:0];
            default:        next_s.nmi_en = s.nmi_en;
         endcase
      end

      // a new condition wins over a clear in the same cycle
      next_s.flag     = (s.flag & ~clr_src) | I_SRC_COND;
      next_s.nmi_flag = (s.nmi_flag & ~clr_nmi) | I_NMI_COND;

      // read data prepared in the wait cycle
      next_s.rdata = 32'h0;
      unique case (I_AVS_ADDRESS)
         `MIC_REG_STATUS:
            next_s.rdata = {24'h0, s.exec.nmi, 4'h0, s.exec.high, s.exec.level_medium, s.exec.low};
         `MIC_REG_PRIO:   next_s.rdata = {24'h0, s.last_low_vector};
         `MIC_REG_CTRL:   next_s.rdata = {24'h0, s.round_robin_enable, 4'h0, s.lvl_en};
         `MIC_REG_FLAGS:
            next_s.rdata = {22'h0, s.nmi_flag, s.flag};
         `MIC_REG_NMIEN:  next_s.rdata = {30'h0, s.nmi_en};
         default:         next_s.rdata = 32'h0;
      endcase
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RSTN)
      begin
         s.st                 <= MIC_ST_IDLE;
         s.cnt                <= 5'h0;
         s.flag               <= '0;
         s.nmi_flag           <= '0;
         s.nmi_en             <= `MIC_NMIEN_RST;
         s.last_low_vector    <= `MIC_PRIO_RST;
         s.round_robin_enable <= 1'b0;
         s.lvl_en             <= `MIC_CTRL_RST;
         s.exec               <= '0;
         s.hold               <= 1'b0;
         s.ccp_cnt            <= 3'h0;
         s.gie_q              <= 1'b0;
         s.win_rank           <= MIC_RANK_NONE;
         s.win_idx            <= '0;
         s.vec                <= `MIC_RESET_VEC;
         s.pc_load            <= 1'b0;
         s.rdata              <= 32'h0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign O_AVS_READDATA = s.rdata;
   assign O_IRQ_REQ      = (s.st == MIC_ST_REQ);
   assign O_IRQ_VEC      = s.vec;
   assign O_PUSH         = (s.st == MIC_ST_RESP);
   assign O_JUMP         = (s.st == MIC_ST_JUMP);
   assign O_PC_LOAD      = s.pc_load;
   assign O_PC_VEC       = s.vec;
   assign O_POP          = (s.st == MIC_ST_RET);
   assign O_EXEC         = s.exec;

endmodule // mic_ctrl

// File: mic_ctrl_checker.sv
// concurrent checks on the interrupt controller ports
`timescale 1ns/100ps
module mic_ctrl_checker
   import mic_pkg::*;
(
   input wire logic                 I_CLK,     // cpu clock
   input wire logic                 I_RSTN,    // sync reset
   input wire mic_pkg::mic_cpu_in_t I_CPU,     // cpu strobes
   input wire logic                 O_IRQ_REQ, // vector shown
   input wire logic [7:0]           O_IRQ_VEC, // shown vector
   input wire logic                 O_PUSH,    // push phase
   input wire logic                 O_JUMP,    // jump phase
   input wire logic                 O_PC_LOAD, // pc load
   input wire logic [7:0]           O_PC_VEC,  // pc value
   input wire logic                 O_POP,     // pop phase
   input wire mic_pkg::mic_exec_t   O_EXEC     // executing levels
);
   logic [7:0] ack_vec;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   // vector held at the acknowledge
   always_ff @(posedge I_CLK)
   begin
      if (O_IRQ_REQ && I_CPU.ack)
      begin
         ack_vec <= O_IRQ_VEC;
      end
   end
   push_five_a: assert property ($rose(O_PUSH) && !$past(I_CPU.sleep)
      |-> O_PUSH[*5] ##1 O_JUMP) else $error("push length");
   wake_push_a: assert property ($rose(O_PUSH) && $past(I_CPU.sleep)
      |-> O_PUSH[*7] ##1 O_PUSH[*7] ##1 O_JUMP) else $error("wake length");
   jump_three_a: assert property ($rose(O_JUMP) |-> O_JUMP[*3] ##1 O_PC_LOAD)
      else $error("jump length");
   pc_vector_a: assert property (O_PC_LOAD |-> O_PC_VEC == ack_vec && ack_vec > 8'h00)
      else $error("pc vector");
   pop_five_a: assert property ($rose(O_POP) |-> O_POP[*5] ##1 !O_POP)
      else $error("pop length");
   gie_mask_a: assert property ($rose(O_IRQ_REQ) && !$past(I_CPU.gie)
      |-> O_IRQ_VEC < 8'h03) else $error("masked request");
   ccp_quiet_a: assert property (I_CPU.ccp_sig |-> ##2 (!$rose(O_IRQ_REQ))[*3])
      else $error("request in window");
   nmi_sole_a: assert property ($rose(O_IRQ_REQ) |-> !$past(O_EXEC.nmi))
      else $error("nmi preempted");
endmodule // mic_ctrl_checker

// File: mic_cpu_model.sv
// cpu core model: acknowledges vectors, ends instructions, returns
`timescale 1ns/100ps
module mic_cpu_model
   import mic_pkg::*;
(
   input  wire logic            i_clk,  // cpu clock
   input  wire logic            i_req,  // vector shown
   input  wire logic            i_slow, // late acknowledge
   input  wire logic [3:0]      i_ctl,  // gie, sleep, signature, return
   output mic_pkg::mic_cpu_in_t o_cpu   // status and strobes
);
   logic [1:0] cnt = 2'h0;
   initial o_cpu = '0;
   always @(posedge i_clk)
   begin
      cnt <= cnt + 2'h1;
      o_cpu.gie <= i_ctl[3];
      o_cpu.sleep <= i_ctl[2];
      o_cpu.ccp_sig <= i_ctl[1];
      o_cpu.interrupt_return_instruction <= i_ctl[0];
      o_cpu.boundary <= cnt != 2'h2; // two-cycle instruction
      o_cpu.insn_done <= cnt[0];
      // late acknowledge lands while the request still stands at a boundary
      o_cpu.ack <= i_req && !o_cpu.ack && (!i_slow || cnt == 2'h1);
   end
endmodule // mic_cpu_model

// File: tb_mic_ctrl.sv
// self-checking bench of the interrupt controller
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
   $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module tb_mic_ctrl;
   import mic_pkg::*;
   logic           clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, slow = 1'b0;
   logic [9:0]     cond = 10'h000;
   logic [2:0]     addr = 3'h0;
   logic [3:0]     ctl = 4'h0;
   logic [31:0]    wd = 32'h0, seed = 32'hA9DF8A94, rdt, rdata;
   logic           wt, req, jump, push, pcl, pop;
   logic [7:0]     vec, pcv;
   mic_lvl_t [7:0] lvl;
   mic_cpu_in_t    cpu;
   mic_exec_t      exec;
   int             n_fail = 0, check_count = 0, cyc = 0, ctrl, lastv = 0, s, l, mf[10], lv[8];
   mic_ctrl mic_ctrl_i (.I_CLK(clk), .I_RSTN(rstn), .I_SRC_COND(cond[7:0]), .I_SRC_LVL(lvl),
      .I_NMI_COND(cond[9:8]), .I_CPU(cpu), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
      .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wt),
      .O_IRQ_REQ(req), .O_IRQ_VEC(vec), .O_PUSH(push), .O_JUMP(jump), .O_PC_LOAD(pcl),
      .O_PC_VEC(pcv), .O_POP(pop), .O_EXEC(exec));
   mic_cpu_model mic_cpu_model_i (.i_clk(clk), .i_req(req), .i_slow(slow), .i_ctl(ctl),
      .o_cpu(cpu));
   always #2.5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end
   function logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function int flg();
      flg = 0;
      for (int k = 0; k < 10; k++) flg = flg | (mf[k] << k);
   endfunction
   // next source to serve, -1 when none
   function int pick();
      int b, t;
      b = -1;
      for (int k = 9; k > 7; k--) if (mf[k] != 0) b = k;
      for (int v = 3; v > 0 && b < 0; v--)
         for (int j = 0; j < 8 && ctrl[v-1]; j++)
         begin
            t = (v == 1 && ctrl[7] && lastv > 2 && lastv < 11) ? (lastv - 2 + j) % 8 : j;
            if (b < 0 && mf[t] != 0 && lv[t] == v) b = t;
         end
      return b;
   endfunction
   task av(input logic w, input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wd <= d;
      @(posedge clk iff wt === 1'b0);
      rdt = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      for (int j = 0; j < 8; j++) lvl[j] = MIC_LVL_OFF;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      for (int r = 0; r < 8; r++)
      begin
         ctl <= 4'h0;
         av(1'b1, 3'h4, 32'h0);
         av(1'b1, 3'h3, 32'h3FF);
         seed = xs(seed);
         ctrl = {seed[31], 4'h0, seed[2:0]};
         av(1'b1, 3'h2, 32'(ctrl));
         for (int j = 0; j < 8; j++)
         begin
            lv[j] = seed[8+2*j+:2];
            lvl[j] <= mic_lvl_t'(seed[8+2*j+:2]);
         end
         seed = xs(seed);
         for (int j = 0; j < 10; j++) mf[j] = seed[j];
         cond <= seed[9:0];
         slow <= seed[10];
         @(posedge clk);
         cond <= 10'h000;
         av(1'b0, 3'h3, 32'h0);
         `CHK(rdt, 32'(flg()))
         av(1'b1, 3'h4, 32'h3);
         ctl <= {1'b1, seed[11], 2'b10};
         @(posedge clk);
         ctl[1] <= 1'b0;
         for (s = pick(); s >= 0; s = pick())
         begin
            do @(negedge clk); while (pcl !== 1'b1);
            l = s > 7 ? 8 : 1 << (lv[s] - 1);
            `CHK(pcv, 8'(s > 7 ? s - 7 : s + 3))
            `CHK(exec, 4'(l))
            mf[s] = 0;
            if (s < 8 && l == 1 && ctrl[7]) lastv = s + 3;
            av(1'b0, 3'h0, 32'h0);
            `CHK(rdt, 32'(s > 7 ? 128 : l))
            ctl[0] <= 1'b1;
            @(posedge clk);
            ctl[0] <= 1'b0;
            do @(negedge clk); while (pop !== 1'b1);
            do @(negedge clk); while (pop === 1'b1);
            `CHK(exec, 4'h0)
         end
         av(1'b0, 3'h3, 32'h0);
         `CHK(rdt, 32'(flg()))
         av(1'b0, 3'h1, 32'h0);
         `CHK(rdt, 32'(lastv))
         av(1'b0, 3'h2, 32'h0);
         `CHK(rdt, 32'(ctrl))
         $display("round %0d done", r);
      end
      av(1'b0, 3'h5, 32'h0);
      `CHK(rdt, 32'h0)
      tally_and_finish();
   end
endmodule // tb_mic_ctrl
bind mic_ctrl mic_ctrl_checker mic_ctrl_checker_i (.I_CLK, .I_RSTN, .I_CPU, .O_IRQ_REQ,
   .O_IRQ_VEC, .O_PUSH, .O_JUMP, .O_PC_LOAD, .O_PC_VEC, .O_POP, .O_EXEC);
